/* dv/timer16_wave_monitor.sv */
// Port checker for the 16-bit waveform timer
`timescale 1ns/10ps
module timer16_wave_monitor (
  input wire logic                         clk,
  input wire logic                         reset,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [timer_pkg::ADDR_W-1:0] paddr,
  input wire logic                         pready,
  input wire logic [timer_pkg::DATA_W-1:0] prdata,
  input wire logic                         pslverr,
  input wire logic                         channel_a_pin_out,
  input wire logic                         channel_a_pin_oe_n
);
  import timer_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Bus answer timing and shape
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_ready_wait: assert property (psel && penable && !$past(penable) |=> pready)
    else $error("pready missing one cycle into access");
  chk_ready_cause: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero between answers");
  chk_bad_addr: assert property (pready && (paddr > PIN_OFF || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unmapped access not refused");
  chk_good_addr: assert property (pready && paddr <= PIN_OFF && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  chk_count_upper: assert property (pready && !pwrite && paddr == COUNT_OFF |-> prdata[31:16] == 16'h0)
    else $error("count read has upper bits set");
  // Wave must stay hidden while the pin is an input
  chk_pin_hidden: assert property (channel_a_pin_oe_n |-> !channel_a_pin_out)
    else $error("wave visible while pin is input");
endmodule : timer16_wave_monitor

bind timer16_wave timer16_wave_monitor mon_u (.clk(clk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .channel_a_pin_out(channel_a_pin_out),
  .channel_a_pin_oe_n(channel_a_pin_oe_n));

/* dv/timer16_wave_tb.sv */
// Self-checking bench for the 16-bit waveform timer
`timescale 1ns/10ps
module timer16_wave_tb;
  import timer_pkg::*;
  logic        clk, reset, psel, penable, pwrite, ovf_ack, pready, err, pslverr;
  logic        irq, pin_out, oe_n;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, cfg;
  int          n_fail = 0;
  int          compares = 0;
  logic [3:0]  pm [4] = '{MODE_PWM8, MODE_PWM9, MODE_PWM10, MODE_PWM_CAP};
  logic [15:0] pt [4] = '{TOP_8BIT, TOP_9BIT, TOP_10BIT, 16'h0040};

  timer16_wave dut_u (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .overflow_ack(ovf_ack), .irq(irq), .channel_a_pin_out(pin_out),
    .channel_a_pin_oe_n(oe_n));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %08X expected %08X", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("Compares %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  // One APB transfer, pready waited for under a bound
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge clk);
    if (pready !== 1'b1) begin
      n_fail++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(rd, e);
  endtask : rdc

  // Tick at divide-by-one for 4 + extra clocks, then stop
  task automatic run(input int extra);
    wr(CTRL_OFF, cfg | 32'h100);
    repeat (extra) @(posedge clk);
    wr(CTRL_OFF, cfg);
  endtask : run

  task automatic t_reset();
    check({irq, pin_out, oe_n}, 32'h1);
    rdc(COUNT_OFF, 32'h0);
    rdc(PIN_OFF, 32'h0);
    xfer(1'b0, 8'h1C, 32'h0);
    check(err, 32'h1);
  endtask : t_reset

  // Normal wrap with set action, overflow, irq and hardware clear
  task automatic t_normal();
    cfg = 32'h30;
    wr(CTRL_OFF, cfg);
    wr(MASK_OFF, 32'h1);
    wr(COUNT_OFF, 32'hFFFE);
    run(0);
    rdc(COUNT_OFF, 32'h2);
    rdc(STATUS_OFF, 32'h3);
    rdc(PIN_OFF, 32'h2);
    check(irq, 32'h1);
    @(posedge clk) ovf_ack <= 1'b1;
    @(posedge clk) ovf_ack <= 1'b0;
    rdc(STATUS_OFF, 32'h2);
    check(irq, 32'h0);
  endtask : t_normal

  // Clear-on-match with compare A and capture as top, toggle action
  task automatic t_ctc();
    int i;
    wr(PIN_OFF, 32'h1);
    for (i = 0; i < 2; i++) begin
      cfg = i ? 32'h1C : 32'h14;
      wr(CTRL_OFF, cfg);
      wr(CMPA_OFF, i ? 32'h100 : 32'h2);
      wr(CAPT_OFF, i ? 32'h2 : 32'h100);
      wr(COUNT_OFF, 32'h0);
      wr(STATUS_OFF, 32'h7);
      run(0);
      rdc(COUNT_OFF, 32'h1);
      rdc(STATUS_OFF, i ? 32'h4 : 32'h2);
      check({oe_n, pin_out}, 32'h0);
    end
    // Count already above top runs through the wrap
    cfg = 32'h04;
    wr(CMPA_OFF, 32'h3);
    wr(COUNT_OFF, 32'hFFFE);
    wr(STATUS_OFF, 32'h7);
    run(0);
    rdc(COUNT_OFF, 32'h2);
    rdc(STATUS_OFF, 32'h1);
  endtask : t_ctc

  // Fast PWM tops, buffered compare A and both polarities
  task automatic t_pwm();
    int i;
    cfg = 32'h0;
    wr(CTRL_OFF, cfg);
    wr(CMPA_OFF, 32'h10);
    for (i = 0; i < 8; i++) begin
      cfg = {28'h0, pm[i/2]} | (i[0] ? 32'h20 : 32'h30);
      wr(CTRL_OFF, cfg);
      wr(CAPT_OFF, 32'h40);
      wr(CMPA_OFF, 32'h1);
      wr(COUNT_OFF, {16'h0, pt[i/2] - 16'h2});
      wr(STATUS_OFF, 32'h7);
      run(1);
      rdc(COUNT_OFF, 32'h2);
      rdc(STATUS_OFF, i / 2 == 3 ? 32'h7 : 32'h3);
      check(pin_out, {31'h0, i[0]});
    end
    wr(PIN_OFF, 32'h0);
    rdc(PIN_OFF, 32'h2);
    check({oe_n, pin_out}, 32'h2);
  endtask : t_pwm

  // Fast PWM with compare A as top: new top waits for the old top, toggle action
  task automatic t_pwm_a();
    cfg = 32'h1F;
    wr(CTRL_OFF, cfg);
    wr(CMPA_OFF, 32'h3);
    rdc(CMPA_OFF, 32'h3);
    wr(COUNT_OFF, 32'h0);
    wr(STATUS_OFF, 32'h7);
    run(1);
    rdc(COUNT_OFF, 32'h3);
    rdc(STATUS_OFF, 32'h3);
    rdc(PIN_OFF, 32'h0);
    run(0);
    rdc(PIN_OFF, 32'h2);
  endtask : t_pwm_a

  // Divide by 8 gives two ticks in 22 clocks; 64, 256, 1024 one tick in 1.5 N clocks
  task automatic t_presc();
    int i;
    cfg = 32'h20;
    wr(CTRL_OFF, cfg);
    wr(COUNT_OFF, 32'h3);
    wr(CMPA_OFF, 32'h4);
    wr(CTRL_OFF, 32'h220);
    repeat (18) @(posedge clk);
    wr(CTRL_OFF, cfg);
    rdc(COUNT_OFF, 32'h5);
    rdc(PIN_OFF, 32'h0);
    for (i = 3; i < 6; i++) begin
      wr(COUNT_OFF, 32'h0);
      wr(CTRL_OFF, {21'h000000, i[2:0], 8'h00});
      repeat (3 << (2 * i - 1)) @(posedge clk);
      wr(CTRL_OFF, 32'h0);
      rdc(COUNT_OFF, 32'h1);
    end
  endtask : t_presc

  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, ovf_ack} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_normal();
    t_ctc();
    t_pwm();
    t_pwm_a();
    t_presc();
    conclude();
  end
endmodule : timer16_wave_tb

/* verilog/timer16_wave.sv */
// 16-bit timer with normal, clear-on-match and fast PWM modes behind an APB slave
`timescale 1ns/10ps
module timer16_wave
  import timer_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [timer_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [timer_pkg::DATA_W-1:0]  pwdata,
  output logic                               pready,
  output logic      [timer_pkg::DATA_W-1:0]  prdata,
  output logic                               pslverr,
  input  wire logic                          overflow_ack,
  output logic                               irq,
  output logic                               channel_a_pin_out,
  output logic                               channel_a_pin_oe_n
);
  import timer_pkg::*;

  logic [3:0]  waveform_mode_sel;
  logic [1:0]  channel_a_output_action;
  logic [2:0]  clk_sel_reg;
  logic [15:0] count_value;
  logic [15:0] compare_a_value;
  logic [15:0] compare_a_buf_reg;
  logic [15:0] capture_value;
  logic [2:0]  status_reg;
  logic [2:0]  mask_reg;
  logic        channel_a_pin_direction;
  logic        channel_a_wave;
  logic        block_reg;
  logic [9:0]  div_reg;
  logic [9:0]  div_limit;
  logic        tick;
  logic        ready_reg;
  logic [31:0] rdata_next;
  logic        addr_ok;
  logic        access;
  logic        wr;
  logic        is_pwm;
  logic        is_ctc;
  logic [15:0] top_value;
  logic        at_top;
  logic        at_max;
  logic        match_a;
  logic        count_wr;
  logic [2:0]  flag_set;

  // Mode decode
  assign is_pwm = (waveform_mode_sel == MODE_PWM8) || (waveform_mode_sel == MODE_PWM9) ||
                  (waveform_mode_sel == MODE_PWM10) || (waveform_mode_sel == MODE_PWM_CAP) ||
                  (waveform_mode_sel == MODE_PWM_A);
  assign is_ctc = (waveform_mode_sel == MODE_CTC_A) || (waveform_mode_sel == MODE_CTC_CAP);

  // Top value per mode; output action takes no part here
  always_comb begin
    unique case (waveform_mode_sel)
      MODE_CTC_A, MODE_PWM_A:     top_value = compare_a_value;
      MODE_CTC_CAP, MODE_PWM_CAP: top_value = capture_value;
      MODE_PWM8:                  top_value = TOP_8BIT;
      MODE_PWM9:                  top_value = TOP_9BIT;
      MODE_PWM10:                 top_value = TOP_10BIT;
      default:                    top_value = COUNT_MAX;
    endcase
  end

  assign at_top  = (count_value == top_value);
  assign at_max  = (count_value == COUNT_MAX);
  assign match_a = (count_value == compare_a_value) && !block_reg;

  // Prescaler select
  always_comb begin
    unique case (clk_sel_reg)
      3'h1:    div_limit = DIV1_M1;
      3'h2:    div_limit = DIV8_M1;
      3'h3:    div_limit = DIV64_M1;
      3'h4:    div_limit = DIV256_M1;
      default: div_limit = DIV1024_M1;
    endcase
  end

  // Prescale divider; tick is a one-cycle enable, stopped when select is 0
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_reg <= DIV_RST;
      tick    <= 1'b0;
    end else if (clk_sel_reg == CLKSEL_RST || clk_sel_reg > 3'h5) begin
      div_reg <= DIV_RST;
      tick    <= 1'b0;
    end else if (div_reg >= div_limit) begin
      div_reg <= DIV_RST;
      tick    <= 1'b1;
    end else begin
      div_reg <= div_reg + 10'h001;
      tick    <= 1'b0;
    end
  end

  // APB handshake: one wait state, registered answer
  assign addr_ok  = (paddr == CTRL_OFF) || (paddr == COUNT_OFF) || (paddr == CMPA_OFF) ||
                    (paddr == CAPT_OFF) || (paddr == STATUS_OFF) || (paddr == MASK_OFF) ||
                    (paddr == PIN_OFF);
  assign access   = psel && penable && ready_reg;
  assign wr       = access && pwrite && addr_ok;
  assign count_wr = wr && (paddr == COUNT_OFF);

  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (paddr)
      CTRL_OFF:   rdata_next = {21'h000000, clk_sel_reg, 2'h0, channel_a_output_action,
                                waveform_mode_sel};
      COUNT_OFF:  rdata_next = {16'h0000, count_value};
      CMPA_OFF:   rdata_next = {16'h0000, is_pwm ? compare_a_buf_reg : compare_a_value};
      CAPT_OFF:   rdata_next = {16'h0000, capture_value};
      STATUS_OFF: rdata_next = {29'h00000000, status_reg};
      MASK_OFF:   rdata_next = {29'h00000000, mask_reg};
      PIN_OFF:    rdata_next = {30'h00000000, channel_a_wave, channel_a_pin_direction};
      default:    rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ready_reg <= 1'b0;
      prdata    <= 32'h0000_0000;
      pslverr   <= 1'b0;
    end else if (psel && penable && !ready_reg) begin
      ready_reg <= 1'b1;
      prdata    <= pwrite ? 32'h0000_0000 : rdata_next;
      pslverr   <= !addr_ok;
    end else begin
      ready_reg <= 1'b0;
      prdata    <= 32'h0000_0000;
      pslverr   <= 1'b0;
    end
  end
  assign pready = ready_reg;

  // Configuration registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      waveform_mode_sel       <= MODE_RST;
      channel_a_output_action <= ACT_RST;
      clk_sel_reg             <= CLKSEL_RST;
      capture_value           <= WORD16_RST;
      mask_reg                <= FLAGS_RST;
      channel_a_pin_direction <= 1'b0;
    end else if (wr) begin
      unique case (paddr)
        CTRL_OFF: begin
          waveform_mode_sel       <= pwdata[MODE_LSB +: 4];
          channel_a_output_action <= pwdata[ACT_LSB +: 2];
          clk_sel_reg             <= pwdata[CLKSEL_LSB +: 3];
        end
        CAPT_OFF: capture_value <= pwdata[15:0];
        MASK_OFF: mask_reg <= pwdata[2:0];
        PIN_OFF:  channel_a_pin_direction <= pwdata[0];
        default:  ;
      endcase
    end
  end

  // Compare A: direct in non-PWM modes, buffered and loaded at top in fast PWM
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      compare_a_value   <= WORD16_RST;
      compare_a_buf_reg <= WORD16_RST;
    end else begin
      if (wr && paddr == CMPA_OFF) begin
        compare_a_buf_reg <= pwdata[15:0];
      end
      if (wr && paddr == CMPA_OFF && !is_pwm) begin
        compare_a_value <= pwdata[15:0];
      end else if (tick && is_pwm && at_top) begin
        compare_a_value <= compare_a_buf_reg;
      end
    end
  end

  // Counter: software write wins, otherwise advance on tick
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_value <= WORD16_RST;
    end else if (count_wr) begin
      count_value <= pwdata[15:0];
    end else if (tick) begin
      if ((is_ctc || is_pwm) && at_top) begin
        count_value <= COUNT_BOTTOM;
      end else begin
        count_value <= count_value + 16'h0001;
      end
    end
  end

  // A count write hides compare matches for the next tick
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      block_reg <= 1'b0;
    end else if (count_wr) begin
      block_reg <= 1'b1;
    end else if (tick) begin
      block_reg <= 1'b0;
    end
  end

  // Flag events raised on a tick
  always_comb begin
    flag_set = FLAGS_RST;
    if (tick) begin
      if (is_pwm) begin
        flag_set[OVF_BIT]  = at_top;
        flag_set[CMPA_BIT] = match_a;
        flag_set[CAPT_BIT] = at_top && (waveform_mode_sel == MODE_PWM_CAP);
      end else if (is_ctc) begin
        flag_set[OVF_BIT]  = at_max && !at_top;
        flag_set[CMPA_BIT] = (waveform_mode_sel == MODE_CTC_A) && match_a;
        flag_set[CAPT_BIT] = (waveform_mode_sel == MODE_CTC_CAP) && at_top
                             && !block_reg;
      end else begin
        flag_set[OVF_BIT]  = at_max;
        flag_set[CMPA_BIT] = match_a;
      end
    end
  end

  // Sticky status, write one to clear, set wins over any clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_reg <= FLAGS_RST;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (flag_set[i]) begin
          status_reg[i] <= 1'b1;
        end else if (wr && paddr == STATUS_OFF && pwdata[i]) begin
          status_reg[i] <= 1'b0;
        end else if (i == OVF_BIT && overflow_ack) begin
          status_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Channel A wave state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      channel_a_wave <= 1'b0;
    end else if (tick) begin
      if (is_pwm) begin
        unique case (channel_a_output_action)
          ACT_CLEAR: begin
            if (match_a) channel_a_wave <= 1'b1;
            else if (at_top) channel_a_wave <= 1'b0;
          end
          ACT_SET: begin
            if (match_a) channel_a_wave <= 1'b0;
            else if (at_top) channel_a_wave <= 1'b1;
          end
          ACT_TOGGLE: begin
            if (match_a && waveform_mode_sel == MODE_PWM_A) begin
              channel_a_wave <= !channel_a_wave;
            end
          end
          ACT_NONE: ;
        endcase
      end else if (match_a) begin
        unique case (channel_a_output_action)
          ACT_TOGGLE: channel_a_wave <= !channel_a_wave;
          ACT_CLEAR:  channel_a_wave <= 1'b0;
          ACT_SET:    channel_a_wave <= 1'b1;
          ACT_NONE:   ;
        endcase
      end
    end
  end

  // Pin and interrupt outputs, all registered
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      channel_a_pin_out  <= 1'b0;
      channel_a_pin_oe_n <= 1'b1;
      irq                <= 1'b0;
    end else begin
      channel_a_pin_out  <= channel_a_pin_direction && channel_a_wave;
      channel_a_pin_oe_n <= !channel_a_pin_direction;
      irq                <= |(status_reg & mask_reg);
    end
  end
endmodule : timer16_wave

/* verilog/timer_pkg.sv */
// Constants for the 16-bit waveform timer and its APB register map
// How it works
// - Counting sequence follows only waveform_mode_sel; output action never alters counting.
// - Non-PWM: action sets, clears or toggles; PWM: action picks polarity.
// - Mode 0 always increments, wraps 0xFFFF to 0x0000, never clears early.
// - Normal mode sets overflow flag on the tick count becomes zero.
// - Overflow flag clears by hardware when its interrupt is serviced.
// - Count value may be written by software at any time.
// - Clear-on-match raises compare A or capture flag, whichever defines top.
// - Clear-on-match top is unbuffered; a missed match runs through 0xFFFF.
// - Clear-on-match with action 1 toggles channel A on each match.
// - Channel A wave reaches the pin only while its direction bit is 1.
// - Timer tick is clk divided by 1, 8, 64, 256 or 1024.
// - Clear-on-match sets overflow flag when count passes max to 0x0000 while top is below max.
// - Modes 5, 6, 7, 14, 15 are fast PWM, single slope.
// - Non-inverting: set on match, clear at top; inverting the opposite.
// - Action 0 leaves the channel output unchanged on a match.
// - Fast PWM top is fixed, capture or compare A; clear tick after top.
// - Fast PWM compare A is buffered, loaded at top with clear and overflow.
package timer_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  // Register byte offsets
  localparam logic [7:0]  CTRL_OFF      = 8'h00;
  localparam logic [7:0]  COUNT_OFF     = 8'h04;
  localparam logic [7:0]  CMPA_OFF      = 8'h08;
  localparam logic [7:0]  CAPT_OFF      = 8'h0C;
  localparam logic [7:0]  STATUS_OFF    = 8'h10;
  localparam logic [7:0]  MASK_OFF      = 8'h14;
  localparam logic [7:0]  PIN_OFF       = 8'h18;
  // Control field positions
  localparam int          MODE_LSB      = 0;
  localparam int          ACT_LSB       = 4;
  localparam int          CLKSEL_LSB    = 8;
  // Status bit positions
  localparam int          OVF_BIT       = 0;
  localparam int          CMPA_BIT      = 1;
  localparam int          CAPT_BIT      = 2;
  // Reset values
  localparam logic [3:0]  MODE_RST      = 4'h0;
  localparam logic [1:0]  ACT_RST       = 2'h0;
  localparam logic [2:0]  CLKSEL_RST    = 3'h0;
  localparam logic [15:0] WORD16_RST    = 16'h0000;
  localparam logic [2:0]  FLAGS_RST     = 3'h0;
  // Waveform modes
  localparam logic [3:0]  MODE_NORMAL   = 4'h0;
  localparam logic [3:0]  MODE_CTC_A    = 4'h4;
  localparam logic [3:0]  MODE_PWM8     = 4'h5;
  localparam logic [3:0]  MODE_PWM9     = 4'h6;
  localparam logic [3:0]  MODE_PWM10    = 4'h7;
  localparam logic [3:0]  MODE_CTC_CAP  = 4'hC;
  localparam logic [3:0]  MODE_PWM_CAP  = 4'hE;
  localparam logic [3:0]  MODE_PWM_A    = 4'hF;
  // Output actions
  localparam logic [1:0]  ACT_NONE      = 2'h0;
  localparam logic [1:0]  ACT_TOGGLE    = 2'h1;
  localparam logic [1:0]  ACT_CLEAR     = 2'h2;
  localparam logic [1:0]  ACT_SET       = 2'h3;
  // Counter limits
  localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
  localparam logic [15:0] COUNT_BOTTOM  = 16'h0000;
  localparam logic [15:0] TOP_8BIT      = 16'h00FF;
  localparam logic [15:0] TOP_9BIT      = 16'h01FF;
  localparam logic [15:0] TOP_10BIT     = 16'h03FF;
  // Prescale divide counts minus one, selected by clock select 1..5
  localparam logic [9:0]  DIV1_M1       = 10'h000;
  localparam logic [9:0]  DIV8_M1       = 10'h007;
  localparam logic [9:0]  DIV64_M1      = 10'h03F;
  localparam logic [9:0]  DIV256_M1     = 10'h0FF;
  localparam logic [9:0]  DIV1024_M1    = 10'h3FF;
  localparam logic [9:0]  DIV_RST       = 10'h000;
endpackage : timer_pkg
